// ==== eir_pkg.sv ====
// constants, codes and reset values of the event interrupt and pin routing block
package eir_pkg;
   localparam int EIR_NPIN = 4;
   localparam int EIR_NFUNC = 32;
   localparam int EIR_SELW = 5;
   // register byte addresses
   localparam logic [7:0] EIR_ADDR_GPIO0 = 8'h00;
   localparam logic [7:0] EIR_ADDR_MASK0 = 8'h50;
   localparam logic [7:0] EIR_ADDR_FLAG0 = 8'hFA;
   // configuration byte layout and reset values
   localparam int EIR_SEL_MSB = 7;
   localparam int EIR_SEL_LSB = 3;
   localparam int EIR_MODE_MSB = 1;
   localparam int EIR_MODE_LSB = 0;
   localparam logic [7:0] EIR_GPIO0_RST = 8'h0A;
   localparam logic [7:0] EIR_GPIOX_RST = 8'hA2;
   localparam logic [1:0] EIR_MODE_ANALOG = 2'h0;
   localparam logic [1:0] EIR_MODE_IN = 2'h1;
   localparam logic [1:0] EIR_MODE_OUT_LO = 2'h2;
   localparam logic [1:0] EIR_MODE_OUT_HI = 2'h3;
   // flag bit positions and reset values
   localparam int EIR_FLAG_CKSUM = 4;
   localparam int EIR_FLAG_SIG0 = 12;
   localparam int EIR_FLAG_WAKE = 15;
   localparam int EIR_FLAG_READY = 16;
   localparam int EIR_FLAG_STBY = 17;
   localparam int EIR_FLAG_LOWBAT = 18;
   localparam int EIR_FLAG_POR = 19;
   localparam logic [31:0] EIR_FLAG_RST = 32'h0008_0000;
   localparam logic [31:0] EIR_MASK_RST = 32'h0000_0000;
   // output function codes
   localparam int EIR_OSEL_IRQ = 0;
   localparam int EIR_OSEL_POR_N = 1;
   localparam int EIR_OSEL_WAKE = 2;
   localparam int EIR_OSEL_LOWBAT = 3;
   localparam int EIR_OSEL_TXCLK = 4;
   localparam int EIR_OSEL_TX = 5;
   localparam int EIR_OSEL_AEMPTY = 6;
   localparam int EIR_OSEL_AFULL = 7;
   localparam int EIR_OSEL_RXDATA = 8;
   localparam int EIR_OSEL_RXCLK = 9;
   localparam int EIR_OSEL_RX = 10;
   localparam int EIR_OSEL_AWAKE = 11;
   localparam int EIR_OSEL_STBY = 12;
   localparam int EIR_OSEL_ANT = 13;
   localparam int EIR_OSEL_PRE = 14;
   localparam int EIR_OSEL_SYNC = 15;
   localparam int EIR_OSEL_CS = 16;
   localparam int EIR_OSEL_TXRX = 18;
   localparam int EIR_OSEL_VDD = 19;
   localparam int EIR_OSEL_GND = 20;
   localparam int EIR_OSEL_SMPS = 21;
   localparam int EIR_OSEL_SLEEP = 22;
   localparam int EIR_OSEL_READY = 23;
   localparam int EIR_OSEL_LOCK = 24;
   localparam int EIR_OSEL_WLOCK = 25;
   localparam int EIR_OSEL_OOK = 26;
   localparam int EIR_OSEL_WXO = 27;
   localparam int EIR_OSEL_WPM = 28;
   localparam int EIR_OSEL_WVCO = 29;
   localparam int EIR_OSEL_SYNTH = 30;
   // input function codes
   localparam logic [4:0] EIR_ISEL_TXCMD = 5'h00;
   localparam logic [4:0] EIR_ISEL_RXCMD = 5'h01;
   localparam logic [4:0] EIR_ISEL_TXDATA = 5'h02;
   localparam logic [4:0] EIR_ISEL_WAKE = 5'h03;
   localparam logic [4:0] EIR_ISEL_LFCLK = 5'h04;
   // external slow clock rate, for reference by users of that input
   localparam int EIR_LFCLK_HZ = 34700;
endpackage : eir_pkg

// ==== eir_gpio_if.sv ====
// carrier between the pin router and its function selector
`timescale 1ns/1ps
`default_nettype none
interface eir_gpio_if;
   import eir_pkg::*;
   logic [EIR_NFUNC-1:0] out_func;
   logic [EIR_NPIN-1:0][EIR_SELW-1:0] sel;
   logic [EIR_NPIN-1:0] pin_level;
   modport router (output out_func, output sel, input pin_level);
   modport selector (input out_func, input sel, output pin_level);
endinterface : eir_gpio_if
`default_nettype wire

// ==== eir_sync2.sv ====
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module eir_sync2 #(
   parameter int W = 4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage is read only by the second stage
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : eir_sync2
`default_nettype wire

// ==== eir_gpio_sel.sv ====
// per-pin selection of one of the internal output functions
`timescale 1ns/1ps
`default_nettype none
module eir_gpio_sel
   import eir_pkg::*;
(
   eir_gpio_if.selector bus
);
   // pure index; reserved codes already read low in out_func
   always_comb begin
      for (int i = 0; i < EIR_NPIN; i++) begin
         bus.pin_level[i] = bus.out_func[bus.sel[i]];
      end
   end
endmodule : eir_gpio_sel
`default_nettype wire

// ==== eir_event_irq.sv ====
// event flags, masks, interrupt request and pin function routing
`timescale 1ns/1ps
`default_nettype none
module eir_event_irq
   import eir_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   // byte register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // event pulses from the packet engine and receiver
   input wire logic [11:0] evt_packet,
   input wire logic [2:0] evt_signal,
   input wire logic wakeup_countdown_done,
   input wire logic por_event,
   // device status levels
   input wire logic crystal_osc_ready,
   input wire logic in_ready,
   input wire logic standby_switching,
   input wire logic low_battery,
   input wire logic por_active,
   input wire logic wakeup_countdown_expired,
   input wire logic tx_data_clock,
   input wire logic in_tx,
   input wire logic in_rx,
   input wire logic queue_almost_empty,
   input wire logic queue_almost_full,
   input wire logic rx_data,
   input wire logic rx_clock,
   input wire logic in_sleep,
   input wire logic in_standby,
   input wire logic antenna_switch,
   input wire logic preamble_flag,
   input wire logic sync_flag,
   input wire logic carrier_sense,
   input wire logic smps_enable,
   input wire logic in_lock,
   input wire logic wait_lock,
   input wire logic tx_data_ook,
   input wire logic wait_crystal,
   input wire logic wait_pm_settle,
   input wire logic wait_vco_cal,
   input wire logic synth_enable,
   // pins
   input wire logic [EIR_NPIN-1:0] gpio_in,
   output logic [EIR_NPIN-1:0] gpio_out,
   output logic [EIR_NPIN-1:0] gpio_oe,
   output logic [EIR_NPIN-1:0] gpio_high_drive,
   output logic interrupt_request_n,
   // input functions taken from pins
   output logic pin_tx_command,
   output logic pin_rx_command,
   output logic pin_tx_data,
   output logic pin_wakeup,
   output logic pin_low_freq_clock
);
   logic [31:0] flags_r;
   logic [31:0] masks_r;
   logic [EIR_NPIN-1:0][7:0] gpio_conf_r;
   logic wake_pend_r;
   logic ready_d_r;
   logic [7:0] rdata_nxt;
   logic [31:0] set_vec;
   logic [31:0] clr_vec;
   logic [31:0] flags_nxt;
   logic ready_entry;
   logic wake_set;
   logic irq_n_nxt;
   logic [EIR_NPIN-1:0] pin_sync;
   logic [EIR_NPIN-1:0] oe_nxt;
   logic [EIR_NPIN-1:0] hi_nxt;
   logic [EIR_NPIN-1:0] in_mode;
   logic [4:0] in_func;
   eir_gpio_if gbus ();

   // byte lane of a 4-byte register group at base, or none
   function automatic logic [2:0] lane_of(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] off;
      off = a - base;
      lane_of = (a >= base && off < 8'h04) ? {1'b1, off[1:0]} : 3'b000;
   endfunction

   wire [2:0] gpio_hit = lane_of(reg_addr, EIR_ADDR_GPIO0);
   wire [2:0] mask_hit = lane_of(reg_addr, EIR_ADDR_MASK0);
   wire [2:0] flag_hit = lane_of(reg_addr, EIR_ADDR_FLAG0);
   wire flag_read = reg_rd && flag_hit[2];

   // wake-up flag waits for the crystal clock, so it may lag the expiry
   assign wake_set = (wake_pend_r | wakeup_countdown_done) & crystal_osc_ready;
   // ready flag only on entry into ready with the crystal settled
   assign ready_entry = in_ready & ~ready_d_r & crystal_osc_ready;

   // event set vector; timer events 28, 29 are not part of this block
   always_comb begin
      set_vec = '0;
      set_vec[EIR_FLAG_CKSUM-1:0] = evt_packet[EIR_FLAG_CKSUM-1:0];
      set_vec[6:EIR_FLAG_CKSUM] = evt_packet[6:EIR_FLAG_CKSUM];
      set_vec[10:7] = evt_packet[10:7];
      set_vec[11] = evt_packet[11];
      set_vec[EIR_FLAG_WAKE-1:EIR_FLAG_SIG0] = evt_signal;
      set_vec[EIR_FLAG_WAKE] = wake_set;
      set_vec[EIR_FLAG_READY] = ready_entry;
      set_vec[EIR_FLAG_STBY] = standby_switching;
      set_vec[EIR_FLAG_LOWBAT] = low_battery;
      set_vec[EIR_FLAG_POR] = por_event;
   end

   // reading a flag byte clears that byte; a same-cycle event still lands
   always_comb begin
      clr_vec = '0;
      if (flag_read) begin
         clr_vec[flag_hit[1:0]*8 +: 8] = 8'hFF;
      end
   end
   assign flags_nxt = (flags_r & ~clr_vec) | set_vec;
   // request follows the next flag state so it drops together with the clear
   assign irq_n_nxt = ~|(flags_nxt & masks_r);

   // flag word, power-on flag preset by reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flags_r <= EIR_FLAG_RST;
         interrupt_request_n <= 1'b1;
      end else begin
         flags_r <= flags_nxt;
         interrupt_request_n <= irq_n_nxt;
      end
   end

   // event history for edge and pending tracking
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wake_pend_r <= 1'b0;
         ready_d_r <= 1'b0;
      end else begin
         wake_pend_r <= (wake_pend_r | wakeup_countdown_done) & ~crystal_osc_ready;
         ready_d_r <= in_ready;
      end
   end

   // configuration writes: masks and pin bytes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         masks_r <= EIR_MASK_RST;
         gpio_conf_r[0] <= EIR_GPIO0_RST;
         for (int i = 1; i < EIR_NPIN; i++) begin
            gpio_conf_r[i] <= EIR_GPIOX_RST;
         end
      end else if (reg_wr) begin
         if (mask_hit[2]) begin
            masks_r[mask_hit[1:0]*8 +: 8] <= reg_wdata;
         end
         if (gpio_hit[2]) begin
            gpio_conf_r[gpio_hit[1:0]] <= reg_wdata;
         end
      end
   end

   // read data mux; unmapped bytes read zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (gpio_hit[2]) begin
         rdata_nxt = gpio_conf_r[gpio_hit[1:0]];
      end else if (mask_hit[2]) begin
         rdata_nxt = masks_r[mask_hit[1:0]*8 +: 8];
      end else if (flag_hit[2]) begin
         rdata_nxt = flags_r[flag_hit[1:0]*8 +: 8];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end
   end

   // internal signals offered to the pins; reserved codes stay low
   always_comb begin
      gbus.out_func = '0;
      gbus.out_func[EIR_OSEL_IRQ] = interrupt_request_n;
      gbus.out_func[EIR_OSEL_POR_N] = ~por_active;
      gbus.out_func[EIR_OSEL_WAKE] = wakeup_countdown_expired;
      gbus.out_func[EIR_OSEL_LOWBAT] = low_battery;
      gbus.out_func[EIR_OSEL_TXCLK] = tx_data_clock;
      gbus.out_func[EIR_OSEL_RXDATA] = rx_data;
      gbus.out_func[EIR_OSEL_RXCLK] = rx_clock;
      gbus.out_func[EIR_OSEL_TX] = in_tx;
      gbus.out_func[EIR_OSEL_RX] = in_rx;
      gbus.out_func[EIR_OSEL_TXRX] = in_tx | in_rx;
      gbus.out_func[EIR_OSEL_AEMPTY] = queue_almost_empty;
      gbus.out_func[EIR_OSEL_AFULL] = queue_almost_full;
      gbus.out_func[EIR_OSEL_AWAKE] = ~(in_sleep | in_standby);
      gbus.out_func[EIR_OSEL_STBY] = in_standby;
      gbus.out_func[EIR_OSEL_SLEEP] = in_sleep;
      gbus.out_func[EIR_OSEL_READY] = in_ready;
      gbus.out_func[EIR_OSEL_LOCK] = in_lock;
      gbus.out_func[EIR_OSEL_WLOCK] = wait_lock;
      gbus.out_func[EIR_OSEL_VDD] = 1'b1;
      gbus.out_func[EIR_OSEL_GND] = 1'b0;
      gbus.out_func[EIR_OSEL_ANT] = antenna_switch;
      gbus.out_func[EIR_OSEL_PRE] = preamble_flag;
      gbus.out_func[EIR_OSEL_SYNC] = sync_flag;
      gbus.out_func[EIR_OSEL_CS] = carrier_sense;
      gbus.out_func[EIR_OSEL_SMPS] = smps_enable;
      gbus.out_func[EIR_OSEL_OOK] = tx_data_ook;
      gbus.out_func[EIR_OSEL_WXO] = wait_crystal;
      gbus.out_func[EIR_OSEL_WPM] = wait_pm_settle;
      gbus.out_func[EIR_OSEL_WVCO] = wait_vco_cal;
      gbus.out_func[EIR_OSEL_SYNTH] = synth_enable;
   end

   // per-pin selector and mode decode
   always_comb begin
      for (int i = 0; i < EIR_NPIN; i++) begin
         gbus.sel[i] = gpio_conf_r[i][EIR_SEL_MSB:EIR_SEL_LSB];
         in_mode[i] = gpio_conf_r[i][EIR_MODE_MSB:EIR_MODE_LSB] == EIR_MODE_IN;
         oe_nxt[i] = gpio_conf_r[i][EIR_MODE_MSB];
         hi_nxt[i] = gpio_conf_r[i][EIR_MODE_MSB:EIR_MODE_LSB] == EIR_MODE_OUT_HI;
      end
   end

   eir_gpio_sel u_sel (
      .bus(gbus.selector)
   );

   // pin drive registered; analog and input modes leave the pin undriven
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gpio_out <= '0;
         gpio_oe <= '0;
         gpio_high_drive <= '0;
      end else begin
         gpio_out <= gbus.pin_level;
         gpio_oe <= oe_nxt;
         gpio_high_drive <= hi_nxt;
      end
   end

   // pins come from outside the clock domain
   eir_sync2 #(.W(EIR_NPIN)) u_sync (
      .clock(clock),
      .rstn(rstn),
      .d(gpio_in),
      .q(pin_sync)
   );

   // input functions: any input-mode pin with the code contributes
   always_comb begin
      in_func = '0;
      for (int i = 0; i < EIR_NPIN; i++) begin
         if (in_mode[i]) begin
            unique case (gbus.sel[i])
               EIR_ISEL_TXCMD: in_func[0] = in_func[0] | pin_sync[i];
               EIR_ISEL_RXCMD: in_func[1] = in_func[1] | pin_sync[i];
               EIR_ISEL_TXDATA: in_func[2] = in_func[2] | pin_sync[i];
               EIR_ISEL_WAKE: in_func[3] = in_func[3] | pin_sync[i];
               EIR_ISEL_LFCLK: in_func[4] = in_func[4] | pin_sync[i];
               default: in_func = in_func; // codes 5-31 have no effect
            endcase
         end
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_tx_command <= 1'b0;
         pin_rx_command <= 1'b0;
         pin_tx_data <= 1'b0;
         pin_wakeup <= 1'b0;
         pin_low_freq_clock <= 1'b0;
      end else begin
         pin_tx_command <= in_func[0];
         pin_rx_command <= in_func[1];
         pin_tx_data <= in_func[2];
         pin_wakeup <= in_func[3];
         pin_low_freq_clock <= in_func[4];
      end
   end
endmodule : eir_event_irq
`default_nettype wire

// ==== eir_event_irq_properties.sv ====
// port checker for the event interrupt and pin routing block
`timescale 1ns/1ps
`default_nettype none
module eir_event_irq_properties
   import eir_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [11:0] evt_packet,
   input wire logic low_battery,
   input wire logic [EIR_NPIN-1:0] gpio_in,
   input wire logic [EIR_NPIN-1:0] gpio_out,
   input wire logic [EIR_NPIN-1:0] gpio_oe,
   input wire logic [EIR_NPIN-1:0] gpio_high_drive,
   input wire logic interrupt_request_n,
   input wire logic pin_tx_command
);
   logic [7:0] cfg_r [EIR_NPIN];
   logic [31:0] mask_r;
   logic [2:0] age_r, age_nxt;
   logic [EIR_NPIN-1:0] out_m, hi_m, vdd_m, cmd_m;
   // address decode of the byte port
   wire is_cfg = reg_addr < 8'h04;
   wire is_mask = reg_addr[7:2] == EIR_ADDR_MASK0[7:2];
   wire [7:0] cfg_b = cfg_r[reg_addr[1:0]];
   wire [7:0] mask_b = mask_r[reg_addr[1:0]*8 +: 8];
   // cycles since a configuration write, saturating so it never wraps
   assign age_nxt = (reg_wr && is_cfg) ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
   // shadow of the writable bytes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cfg_r <= '{EIR_GPIO0_RST, EIR_GPIOX_RST, EIR_GPIOX_RST, EIR_GPIOX_RST};
         mask_r <= EIR_MASK_RST;
         age_r <= 3'h0;
      end else begin
         if (reg_wr && is_cfg) cfg_r[reg_addr[1:0]] <= reg_wdata;
         if (reg_wr && is_mask) mask_r[reg_addr[1:0]*8 +: 8] <= reg_wdata;
         age_r <= age_nxt;
      end
   end
   // per-pin decode of the shadowed configuration
   for (genvar k = 0; k < EIR_NPIN; k++) begin : g_pin
      assign out_m[k] = cfg_r[k][1];
      assign hi_m[k] = cfg_r[k][1:0] == EIR_MODE_OUT_HI;
      assign vdd_m[k] = out_m[k] && cfg_r[k][7:3] == 5'(EIR_OSEL_VDD);
      // reserved bit 2 is ignored by the router, so only selector and mode count
      assign cmd_m[k] = cfg_r[k][7:3] == EIR_ISEL_TXCMD && cfg_r[k][1:0] == EIR_MODE_IN;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   oe_mode_a: assert property (1'b1 |=> gpio_oe == $past(out_m))
      else $error("pin enable differs from mode");
   drive_mode_a: assert property (1'b1 |=> gpio_high_drive == $past(hi_m))
      else $error("high drive differs from mode");
   vdd_pin_a: assert property (1'b1 |=> (gpio_out & $past(vdd_m)) == $past(vdd_m))
      else $error("constant high pin is low");
   tx_cmd_a: assert property (age_r > 3'h4 |->
      pin_tx_command == |($past(gpio_in, 3) & cmd_m)) else $error("tx command wrong");
   cfg_rb_a: assert property (reg_rd && is_cfg |=> reg_rdata == $past(cfg_b))
      else $error("pin config read back wrong");
   mask_rb_a: assert property (reg_rd && is_mask |=> reg_rdata == $past(mask_b))
      else $error("mask read back wrong");
   irq_set_a: assert property ((|(evt_packet & mask_r[11:0])) ||
      (low_battery && mask_r[EIR_FLAG_LOWBAT]) |=> !interrupt_request_n)
      else $error("unmasked event did not raise request");
   irq_hold_a: assert property (!interrupt_request_n && !reg_rd && !reg_wr
      |=> !interrupt_request_n) else $error("request dropped without a read");
endmodule // eir_event_irq_properties
bind eir_event_irq eir_event_irq_properties u_props (.clock, .rstn, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .evt_packet, .low_battery, .gpio_in, .gpio_out,
   .gpio_oe, .gpio_high_drive, .interrupt_request_n, .pin_tx_command);
`default_nettype wire

// ==== eir_host_model.sv ====
// host model: byte register strobes and pin input levels
`timescale 1ns/1ps
`default_nettype none
module eir_host_model
   import eir_pkg::*;
(
   input wire logic clock,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   output logic [EIR_NPIN-1:0] gpio_in
);
   // idle bus from time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hFF;
      reg_wdata = 8'h00;
      gpio_in = '0;
   end
   // one strobe per byte, held across exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // data is registered at the edge that takes the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   // levels put on pins set as inputs: commands, tx data, wake-up, slow clock
   task automatic pins(input logic [EIR_NPIN-1:0] v);
      @(negedge clock);
      gpio_in = v;
   endtask
endmodule // eir_host_model
`default_nettype wire

// ==== tb_event_irq_and_pin_routing.sv ====
// self-checking bench for the event interrupt and pin routing block
`timescale 1ns/1ps
`default_nettype none
module tb_event_irq_and_pin_routing
   import eir_pkg::*;
;
   logic clock, rstn, reg_wr, reg_rd, xo, interrupt_request_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [31:0] st;
   logic [19:0] ev_v;
   logic [4:0] pin_fn;
   logic [7:0] mc [EIR_NPIN];
   logic [EIR_NPIN-1:0] gpio_in, gpio_out, gpio_oe, gpio_high_drive;
   int unsigned mf, mm;
   int error_cnt, n_checks;
   // status levels sit on st at the index of their output selection
   eir_event_irq uut (.clock, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .evt_packet(ev_v[11:0]), .evt_signal(ev_v[14:12]), .wakeup_countdown_done(ev_v[15]),
      .por_event(ev_v[19]), .crystal_osc_ready(xo), .in_ready(st[23] | ev_v[16]),
      .standby_switching(ev_v[17]), .low_battery(st[3] | ev_v[18]), .por_active(st[1]),
      .wakeup_countdown_expired(st[2]), .tx_data_clock(st[4]), .in_tx(st[5]), .in_rx(st[10]),
      .queue_almost_empty(st[6]), .queue_almost_full(st[7]), .rx_data(st[8]),
      .rx_clock(st[9]), .in_sleep(st[22]), .in_standby(st[12]), .antenna_switch(st[13]),
      .preamble_flag(st[14]), .sync_flag(st[15]), .carrier_sense(st[16]),
      .smps_enable(st[21]), .in_lock(st[24]), .wait_lock(st[25]), .tx_data_ook(st[26]),
      .wait_crystal(st[27]), .wait_pm_settle(st[28]), .wait_vco_cal(st[29]),
      .synth_enable(st[30]), .gpio_in, .gpio_out, .gpio_oe, .gpio_high_drive,
      .interrupt_request_n, .pin_tx_command(pin_fn[0]), .pin_rx_command(pin_fn[1]),
      .pin_tx_data(pin_fn[2]), .pin_wakeup(pin_fn[3]), .pin_low_freq_clock(pin_fn[4]));
   eir_host_model host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .gpio_in);
   // clock and hang guard
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      repeat (100000) @(posedge clock);
      error_cnt++;
      final_report();
   end
   task automatic final_report();
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD reg %h exp %h got %h", a, e, g);
      end
   endtask
   task automatic chk_pin(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // register write mirrored in the model
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      if (a < 8'h04) mc[a[1:0]] = d;
      if (a[7:2] == 6'h14) mm[a[1:0]*8 +: 8] = d;
   endtask
   // read one byte; a flag byte empties in the model as it is read
   task automatic rcheck(input logic [7:0] a);
      logic [7:0] d, e;
      host.rd(a, d);
      e = 8'h00;
      if (a < 8'h04) e = mc[a[1:0]];
      if (a[7:2] == 6'h14) e = mm[a[1:0]*8 +: 8];
      if (a >= 8'hFA && a <= 8'hFD) e = mf[(a - 8'hFA)*8 +: 8];
      if (a >= 8'hFA && a <= 8'hFD) mf[(a - 8'hFA)*8 +: 8] = 8'h00;
      chk_reg(a, e, d);
   endtask
   // one-cycle event pulse; wake-up and ready need the crystal
   task automatic pulse(input logic [19:0] v);
      @(negedge clock);
      ev_v = v;
      @(negedge clock);
      ev_v = 20'h0;
      if (!xo) v[16:15] = 2'h0;
      mf = mf | v;
      @(negedge clock);
   endtask
   // expected pin levels from the selection of each pin
   task automatic pincheck();
      logic [31:0] f;
      f = st;
      f[0] = (mf & mm) == 0;
      f[1] = ~st[1];
      f[11] = ~(st[22] | st[12]);
      f[17] = 1'b0;
      f[18] = st[5] | st[10];
      f[20:19] = 2'h1;
      f[31] = 1'b0;
      for (int k = 0; k < EIR_NPIN; k++) begin
         if (mc[k][1]) chk_pin("gpio_out", f[mc[k][7:3]], gpio_out[k]);
         chk_pin("gpio_oe", mc[k][1], gpio_oe[k]);
         chk_pin("gpio_high_drive", mc[k][1:0] == 2'h3, gpio_high_drive[k]);
      end
   endtask
   task automatic incheck();
      logic [4:0] e;
      e = 5'h00;
      for (int k = 0; k < EIR_NPIN; k++) begin
         if (mc[k][1:0] == 2'h1 && mc[k][7:3] < 5'h05 && gpio_in[k]) e[mc[k][7:3]] = 1'b1;
      end
      chk_pin("pin_fn", e, pin_fn);
   endtask
   initial begin
      st = 32'h0;
      ev_v = 20'h0;
      xo = 1'b0;
      rstn = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      mf = EIR_FLAG_RST;
      mm = EIR_MASK_RST;
      mc = '{EIR_GPIO0_RST, EIR_GPIOX_RST, EIR_GPIOX_RST, EIR_GPIOX_RST};
      void'($urandom(32'h6a044165));
      repeat (8) @(negedge clock);
      rstn = 1'b1;
      // reset state, unmapped place and a write to read-only flags
      repeat (2) @(negedge clock);
      pincheck();
      for (int a = 0; a < 4; a++) begin
         rcheck(8'(a));
         rcheck(8'(8'h50 + a));
         rcheck(8'(8'hFA + a));
      end
      w(8'h40, 8'hFF);
      w(EIR_ADDR_FLAG0, 8'hFF);
      rcheck(8'h40);
      rcheck(EIR_ADDR_FLAG0);
      // random masks, each event alone, then random mixtures
      xo = 1'b1;
      for (int b = 0; b < 4; b++) w(8'(8'h50 + b), 8'($urandom));
      for (int i = 0; i < 40; i++) begin
         pulse(20'(i < 20 ? 1 << i : $urandom));
         chk_pin("irq_n", (mf & mm) == 0, interrupt_request_n);
         for (int b = 0; b < 4; b++) rcheck(8'(8'hFA + b));
         chk_pin("irq_n", (mf & mm) == 0, interrupt_request_n);
      end
      // wake-up expiry waits for the crystal; a ready entry without it is lost
      xo = 1'b0;
      pulse(20'h18000);
      rcheck(8'hFB);
      rcheck(8'hFC);
      xo = 1'b1;
      repeat (3) @(negedge clock);
      mf[15] = 1'b1;
      rcheck(8'hFB);
      rcheck(8'hFC);
      // every output selection on a rotating pin with random source levels
      // low battery masked in and forced first, so the request pin is seen low
      xo = 1'b0;
      w(8'h52, 8'hFF);
      for (int s = 0; s < EIR_NFUNC; s++) begin
         @(negedge clock);
         st = $urandom;
         if (s == 0) st[3] = 1'b1;
         if (st[3]) mf[18] = 1'b1;
         w(8'(s % 4), {5'(s), 2'h1, 1'($urandom)});
         repeat (3) @(negedge clock);
         pincheck();
      end
      // input selections, including unused codes, then a pin left undriven
      st = 32'h0;
      for (int s = 0; s < 8; s++) begin
         w(8'(s % 4), {5'(s < 6 ? s : s * 4), 3'h1});
         host.pins(4'($urandom));
         repeat (4) @(negedge clock);
         incheck();
      end
      w(8'h03, 8'h00);
      repeat (3) @(negedge clock);
      pincheck();
      final_report();
   end
endmodule // tb_event_irq_and_pin_routing
`default_nettype wire
